// ===== hdl/power_mode_controller.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defines.svh"
module power_mode_controller #(
  parameter int unsigned RST_DELAY_CYC = `RST_DELAY_CYCLES
) (
  input wire logic clk, // 40 MHz system clock
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic [4:0] address, // Avalon byte address
  input wire logic read, // Avalon read
  input wire logic write, // Avalon write
  input wire logic [31:0] writedata, // Avalon write data
  input wire logic [3:0] byteenable, // Avalon byte lanes
  output logic [31:0] readdata, // Avalon read data
  output logic waitrequest, // Avalon wait
  input wire logic wait_for_interrupt_instr, // Core sleep pulse
  input wire logic wait_for_event_instr, // Core sleep pulse
  input wire logic core_deep_sleep_bit, // Core deep-sleep level
  input wire logic deepest_mode_select_bit, // Deepest mode select
  input wire pmc_pkg::wake_src_t wake_src, // Asynchronous wake events
  output pmc_pkg::clk_gate_t clk_gate, // Clock gate enables
  output logic ram_fetch, // Fetch from RAM
  output logic fast_osc_run, // Fast oscillator on
  output logic fast_osc_suspend, // Fast oscillator suspended
  output logic lowclk_sel, // Run on slow clock
  output logic pins_low_power, // Pins in low power
  output logic std_ram_power, // Ordinary RAM powered
  output logic core_run, // Core may execute
  output logic reset_req, // Wake reset request
  output logic irq // Level interrupt
);

  localparam pmc_pkg::pmc_state_t RESET_ST = '{
    mode: pmc_pkg::ST_BOOT,
    ctrl: `CTRL_RESET,
    clk_en: `CLK_EN_RESET,
    default: '0
  };

  pmc_pkg::pmc_state_t st;
  pmc_pkg::pmc_state_t next_st;

  logic access;
  logic wr;
  logic sleep_req;
  logic [9:0] wake_lvl;
  logic [9:0] wake_hit;
  logic [9:0] pm2_mask;
  logic pm2_wake;
  logic pm3_wake;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;
  logic [31:0] rd_val;
  logic [31:0] wval;

  // Byte-lane merge of a write into a register image.
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic hit(
    input logic [4:0] addr,
    input logic [4:0] off
  );
    return addr[4:2] == off[4:2];
  endfunction

  // Derives every gate and power control from the mode being entered.
  function automatic pmc_pkg::pmc_out_t decode(
    input pmc_pkg::mode_t mode,
    input logic [3:0] ctrl,
    input logic [15:0] clk_en
  );
    pmc_pkg::pmc_out_t o;
    o = '0;
    o.std_ram_power = 1'b1;
    o.fast_osc_run = 1'b1;
    unique case (mode)
      pmc_pkg::ST_BOOT: begin
        o.gate.ahb = 1'b1;
        o.gate.apb = 1'b1;
      end
      pmc_pkg::ST_RUN0: begin
        o.gate.core = 1'b1;
        o.gate.ahb = 1'b1;
        o.gate.apb = 1'b1;
        o.gate.periph = clk_en;
        o.core_run = 1'b1;
      end
      pmc_pkg::ST_RUN1: begin
        o.gate.core = 1'b1;
        o.gate.ahb = 1'b1;
        o.gate.apb = 1'b1;
        o.gate.periph = clk_en;
        o.ram_fetch = 1'b1;
        o.core_run = 1'b1;
      end
      pmc_pkg::ST_HALT2: begin
        o.gate.ahb = ctrl[`CTRL_AHB];
        o.gate.apb = ctrl[`CTRL_APB];
        o.gate.periph = clk_en;
      end
      pmc_pkg::ST_STOP3: begin
        // All bus clocks off, so the fast oscillator has no master left.
        o.fast_osc_run = 1'b0;
        o.fast_osc_suspend = 1'b1;
        o.lowclk_sel = ctrl[`CTRL_FAST];
      end
      pmc_pkg::ST_DEEP9: begin
        o.fast_osc_run = 1'b0;
        o.pins_low_power = 1'b1;
        // Retention RAM has its own supply and is not gated here.
        o.std_ram_power = 1'b0;
      end
    endcase
    return o;
  endfunction

  always_comb begin
    next_st = st;

    // Two-flop synchronisers on the asynchronous wake inputs.
    next_st.sync1 = wake_src;
    next_st.sync2 = st.sync1;
    wake_lvl = st.sync2;
    wake_hit = wake_lvl & st.wake_en;

    // Peripheral-bus sources only reach the core if that clock runs.
    pm2_mask = st.ctrl[`CTRL_APB] ? 10'h3ff : ~`APB_WAKE_MASK;
    pm2_wake = |(wake_hit & pm2_mask);
    pm3_wake = |(wake_hit & `PM3_WAKE_MASK);

    // Core sleep instructions come from the same clock domain.
    sleep_req = wait_for_interrupt_instr | wait_for_event_instr;

    // Bus: one wait cycle, then data and write strobe in the same cycle.
    access = (read | write) & ~st.ack;
    wr = write & st.ack;
    next_st.ack = access;

    rd_val = '0;
    if (hit(address, `REG_CTRL)) begin
      rd_val[3:0] = st.ctrl;
    end else if (hit(address, `REG_WAKE_EN)) begin
      rd_val[9:0] = st.wake_en;
    end else if (hit(address, `REG_CLK_EN)) begin
      rd_val[15:0] = st.clk_en;
    end else if (hit(address, `REG_STATUS)) begin
      rd_val[5:0] = st.mode;
      rd_val[8] = st.ret_ram;
      rd_val[25:16] = wake_lvl;
    end else if (hit(address, `REG_IRQ_STAT)) begin
      rd_val[1:0] = st.irq_stat;
    end else if (hit(address, `REG_IRQ_MASK)) begin
      rd_val[1:0] = st.irq_mask;
    end else if (hit(address, `REG_RST_EN)) begin
      rd_val[9:0] = st.rst_en;
    end
    if (access & read) begin
      next_st.rdata = rd_val;
    end

    irq_clr = '0;
    wval = '0;
    if (wr) begin
      if (hit(address, `REG_CTRL)) begin
        wval = merge({28'h0000000, st.ctrl}, writedata, byteenable);
        next_st.ctrl = wval[3:0];
      end else if (hit(address, `REG_WAKE_EN)) begin
        wval = merge({22'h000000, st.wake_en}, writedata, byteenable);
        next_st.wake_en = wval[9:0];
      end else if (hit(address, `REG_CLK_EN)) begin
        wval = merge({16'h0000, st.clk_en}, writedata, byteenable);
        next_st.clk_en = wval[15:0];
      end else if (hit(address, `REG_IRQ_STAT)) begin
        if (byteenable[0]) begin
          irq_clr = writedata[1:0];
        end
      end else if (hit(address, `REG_IRQ_MASK)) begin
        wval = merge({30'h00000000, st.irq_mask}, writedata, byteenable);
        next_st.irq_mask = wval[1:0];
      end else if (hit(address, `REG_RST_EN)) begin
        wval = merge({22'h000000, st.rst_en}, writedata, byteenable);
        next_st.rst_en = wval[9:0];
      end
    end

    irq_set = '0;
    next_st.dly = st.dly;
    unique case (st.mode)
      pmc_pkg::ST_BOOT: begin
        // Execution is held off for the reset release delay.
        if (st.dly >= 16'(RST_DELAY_CYC - 1)) begin
          next_st.mode = pmc_pkg::ST_RUN0;
          next_st.dly = '0;
        end else begin
          next_st.dly = st.dly + 16'h0001;
        end
      end
      pmc_pkg::ST_RUN0, pmc_pkg::ST_RUN1: begin
        if (sleep_req) begin
          next_st.ret_ram = (st.mode == pmc_pkg::ST_RUN1);
          irq_set[`IRQ_SLEEP] = 1'b1;
          // Selection bits are prepared by software before the sleep.
          if (core_deep_sleep_bit & deepest_mode_select_bit) begin
            next_st.mode = pmc_pkg::ST_DEEP9;
          end else if (core_deep_sleep_bit) begin
            next_st.mode = pmc_pkg::ST_STOP3;
          end else begin
            next_st.mode = pmc_pkg::ST_HALT2;
          end
        end else if (st.ctrl[`CTRL_RAM]) begin
          next_st.mode = pmc_pkg::ST_RUN1;
        end else begin
          next_st.mode = pmc_pkg::ST_RUN0;
        end
      end
      pmc_pkg::ST_HALT2: begin
        if (pm2_wake) begin
          irq_set[`IRQ_WAKE] = 1'b1;
          next_st.mode = st.ret_ram ? pmc_pkg::ST_RUN1 : pmc_pkg::ST_RUN0;
        end
      end
      pmc_pkg::ST_STOP3: begin
        if (pm3_wake) begin
          irq_set[`IRQ_WAKE] = 1'b1;
          next_st.mode = st.ret_ram ? pmc_pkg::ST_RUN1 : pmc_pkg::ST_RUN0;
        end
      end
      pmc_pkg::ST_DEEP9: begin
        // Only a reset leaves this mode; nothing here moves the state.
        next_st.mode = pmc_pkg::ST_DEEP9;
      end
    endcase

    // A hardware set in the same cycle as a clear wins.
    next_st.irq_stat = (st.irq_stat & ~irq_clr) | irq_set;

    next_st.o = decode(next_st.mode, next_st.ctrl, next_st.clk_en);
    next_st.o.reset_req = (st.mode == pmc_pkg::ST_DEEP9) && |(wake_lvl & st.rst_en);
    next_st.o.irq = |(next_st.irq_stat & next_st.irq_mask);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= RESET_ST;
    end else begin
      st <= next_st;
    end
  end

  assign waitrequest = (read | write) & ~st.ack;
  assign readdata = st.rdata;
  assign clk_gate = st.o.gate;
  assign ram_fetch = st.o.ram_fetch;
  assign fast_osc_run = st.o.fast_osc_run;
  assign fast_osc_suspend = st.o.fast_osc_suspend;
  assign lowclk_sel = st.o.lowclk_sel;
  assign pins_low_power = st.o.pins_low_power;
  assign std_ram_power = st.o.std_ram_power;
  assign core_run = st.o.core_run;
  assign reset_req = st.o.reset_req;
  assign irq = st.o.irq;

endmodule
`default_nettype wire

// ===== hdl/pmc_defines.svh
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH
`define REG_CTRL 5'h00
`define REG_WAKE_EN 5'h04
`define REG_CLK_EN 5'h08
`define REG_STATUS 5'h0c
`define REG_IRQ_STAT 5'h10
`define REG_IRQ_MASK 5'h14
`define REG_RST_EN 5'h18
`define CTRL_RAM 0
`define CTRL_FAST 1
`define CTRL_AHB 2
`define CTRL_APB 3
`define CTRL_RESET 4'hc
`define CLK_EN_RESET 16'hffff
`define IRQ_WAKE 0
`define IRQ_SLEEP 1
`define PM3_WAKE_MASK 10'h01f
`define APB_WAKE_MASK 10'h380
`define RST_DELAY_US 10
`define CLK_MHZ 40
`define RST_DELAY_CYCLES (`RST_DELAY_US * `CLK_MHZ)
`endif

// ===== hdl/pmc_pkg.sv
package pmc_pkg;
  typedef enum logic [5:0] {
    ST_BOOT = 6'h01,
    ST_RUN0 = 6'h02,
    ST_RUN1 = 6'h04,
    ST_HALT2 = 6'h08,
    ST_STOP3 = 6'h10,
    ST_DEEP9 = 6'h20
  } mode_t;
  typedef struct packed {
    logic port_ext_b;
    logic port_ext_a;
    logic port_match;
    logic pin_wake;
    logic comparator0;
    logic regulator_low;
    logic supply_low;
    logic low_power_timer;
    logic rtc_osc_failure;
    logic rtc_alarm;
  } wake_src_t;
  typedef struct packed {
    logic core;
    logic ahb;
    logic apb;
    logic [15:0] periph;
  } clk_gate_t;
  typedef struct packed {
    clk_gate_t gate;
    logic ram_fetch;
    logic fast_osc_run;
    logic fast_osc_suspend;
    logic lowclk_sel;
    logic pins_low_power;
    logic std_ram_power;
    logic core_run;
    logic reset_req;
    logic irq;
  } pmc_out_t;
  typedef struct packed {
    mode_t mode;
    logic ret_ram;
    logic [15:0] dly;
    logic [9:0] sync1;
    logic [9:0] sync2;
    logic [3:0] ctrl;
    logic [9:0] wake_en;
    logic [15:0] clk_en;
    logic [9:0] rst_en;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic ack;
    logic [31:0] rdata;
    pmc_out_t o;
  } pmc_state_t;
endpackage

// ===== test/pmc_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pmc_asserts #(
  parameter int unsigned RST_DELAY_CYC = 4
) (
  input wire logic clk, // Clock
  input wire logic resetn, // Reset
  input wire logic read, // Bus read
  input wire logic write, // Bus write
  input wire logic waitrequest, // Bus wait
  input wire logic wait_for_interrupt_instr, // Sleep pulse
  input wire logic wait_for_event_instr, // Sleep pulse
  input wire logic core_deep_sleep_bit, // Deep level
  input wire logic deepest_mode_select_bit, // Deepest select
  input wire pmc_pkg::wake_src_t wake_src, // Wake events
  input wire pmc_pkg::clk_gate_t clk_gate, // Gates
  input wire logic fast_osc_run, // Fast oscillator
  input wire logic fast_osc_suspend, // Oscillator suspended
  input wire logic pins_low_power, // Pins low
  input wire logic std_ram_power, // RAM power
  input wire logic core_run // Core runs
);
  logic slp;
  logic booted;
  logic [15:0] cnt;
  assign slp = (wait_for_interrupt_instr || wait_for_event_instr) && core_run;
  // The counter may wrap on long runs; it only matters before the first boot completes.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 16'h0;
      booted <= 1'b0;
    end else begin
      cnt <= cnt + 16'h1;
      booted <= booted || core_run;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  bus_wait_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus wait longer than one cycle");
  halt_entry_a: assert property (slp && !core_deep_sleep_bit |=> !clk_gate.core && !core_run)
    else $error("sleep did not halt the core");
  stop_entry_a: assert property (slp && core_deep_sleep_bit && !deepest_mode_select_bit
    |=> !clk_gate.ahb && !clk_gate.apb && clk_gate.periph == 16'h0) else $error("bus clocks run in stop");
  osc_suspend_a: assert property (slp && core_deep_sleep_bit && !deepest_mode_select_bit
    |=> fast_osc_suspend && !fast_osc_run) else $error("oscillator not suspended");
  deep_entry_a: assert property (slp && core_deep_sleep_bit && deepest_mode_select_bit
    |=> pins_low_power && !std_ram_power && clk_gate == 19'h0) else $error("deepest mode entry wrong");
  deep_hold_a: assert property (pins_low_power |=> pins_low_power && !core_run)
    else $error("deepest mode left without reset");
  stop_filter_a: assert property ((fast_osc_suspend && wake_src[4:0] == 5'h0) [*4] |=> fast_osc_suspend)
    else $error("stop left without valid wake");
  boot_delay_a: assert property ($rose(core_run) && !booted
    |-> cnt >= 16'(RST_DELAY_CYC) && clk_gate.periph == 16'hffff) else $error("boot too short");
  cover property (slp && !core_deep_sleep_bit);
  cover property (slp && core_deep_sleep_bit && !deepest_mode_select_bit);
  cover property (pins_low_power);
endmodule
bind power_mode_controller pmc_asserts #(.RST_DELAY_CYC(RST_DELAY_CYC)) pmc_asserts_i (.*);
`default_nettype wire

// ===== test/core_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input wire logic clk, // Clock
  output logic wait_for_interrupt_instr, // Sleep pulse
  output logic wait_for_event_instr, // Sleep pulse
  output logic core_deep_sleep_bit, // Deep level
  output logic deepest_mode_select_bit, // Deepest select
  output pmc_pkg::wake_src_t wake_src // Wake levels
);
  initial begin
    wait_for_interrupt_instr = 1'b0;
    wait_for_event_instr = 1'b0;
    core_deep_sleep_bit = 1'b0;
    deepest_mode_select_bit = 1'b0;
    wake_src = '0;
  end
  // Callers leave the bus idle first, which stands in for the two barriers.
  task automatic sleep(input logic ev, input logic dp, input logic sel);
    @(posedge clk);
    core_deep_sleep_bit <= dp;
    deepest_mode_select_bit <= sel;
    @(posedge clk);
    wait_for_event_instr <= ev;
    wait_for_interrupt_instr <= !ev;
    @(posedge clk);
    wait_for_event_instr <= 1'b0;
    wait_for_interrupt_instr <= 1'b0;
  endtask
  task automatic wake(input int idx);
    @(posedge clk);
    wake_src[idx] <= 1'b1;
    repeat (4) @(posedge clk);
    wake_src[idx] <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== test/power_mode_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defines.svh"
module power_mode_controller_tb;
  logic clk, resetn, read, write, waitrequest, irq, core_run, reset_req;
  logic wait_for_interrupt_instr, wait_for_event_instr, core_deep_sleep_bit, deepest_mode_select_bit;
  logic ram_fetch, fast_osc_run, fast_osc_suspend, lowclk_sel, pins_low_power, std_ram_power;
  logic [4:0] address;
  logic [3:0] byteenable;
  logic [31:0] writedata, readdata, rdq;
  pmc_pkg::wake_src_t wake_src;
  pmc_pkg::clk_gate_t clk_gate;
  int num_errors = 0;
  int compares = 0;
  power_mode_controller #(.RST_DELAY_CYC(4)) power_mode_controller_i (.*);
  core_model core_model_i (.*);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic tally_and_finish;
    if (num_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask
  // The strobe rises one edge after entry, so back-to-back calls never drive it twice at once.
  task automatic acc(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    // Only the watchdog may end this wait; the slave's latency is not assumed here.
    do @(negedge clk); while (waitrequest !== 1'b0);
    @(posedge clk);
    rdq = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rc(input logic [4:0] a, input logic [31:0] exp, input string name);
    acc(1'b0, a, 32'h0);
    chk(name, exp, rdq);
  endtask
  task automatic mode(input logic [5:0] exp);
    acc(1'b0, `REG_STATUS, 32'h0);
    chk("mode", 32'(exp), 32'(rdq[5:0]));
  endtask
  task automatic ir(input logic exp);
    repeat (2) @(posedge clk);
    chk("irq", 32'(exp), 32'(irq));
  endtask
  task automatic wcore;
    int n = 0;
    while (core_run !== 1'b1 && n++ < 20) @(negedge clk);
    chk("core_run", 32'h1, 32'(core_run));
  endtask
  initial begin
    resetn = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 5'h0;
    writedata = 32'h0;
    byteenable = 4'hf;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (8) @(posedge clk);
    mode(6'h02);
    rc(`REG_CTRL, 32'hc, "ctrl");
    rc(`REG_CLK_EN, 32'hffff, "clk_en");
    rc(`REG_WAKE_EN, 32'h0, "wake_en");
    rc(5'h1c, 32'h0, "unmapped");
    acc(1'b1, `REG_CLK_EN, 32'ha5);
    repeat (3) @(posedge clk);
    chk("periph", 32'ha5, 32'(clk_gate.periph));
    // A single-lane write must leave the other lanes of the register alone.
    byteenable <= 4'h2;
    acc(1'b1, `REG_CLK_EN, 32'h3c00);
    byteenable <= 4'hf;
    rc(`REG_CLK_EN, 32'h3ca5, "clk_en_lane");
    acc(1'b1, `REG_CTRL, 32'hd);
    mode(6'h04);
    chk("ram_fetch", 32'h1, 32'(ram_fetch));
    acc(1'b1, `REG_CTRL, 32'hc);
    acc(1'b1, `REG_WAKE_EN, 32'h3ff);
    acc(1'b1, `REG_IRQ_MASK, 32'h3);
    core_model_i.sleep(1'b0, 1'b0, 1'b0);
    repeat (2) @(posedge clk);
    chk("halt", 32'h3ca5, 32'({clk_gate.core, clk_gate.periph}));
    core_model_i.wake(7);
    wcore();
    ir(1'b1);
    rc(`REG_IRQ_STAT, 32'h3, "irq_stat");
    acc(1'b1, `REG_IRQ_MASK, 32'h0);
    ir(1'b0);
    acc(1'b1, `REG_IRQ_MASK, 32'h3);
    ir(1'b1);
    acc(1'b1, `REG_IRQ_STAT, 32'h3);
    ir(1'b0);
    rc(`REG_IRQ_STAT, 32'h0, "irq_clear");
    // Halt from RAM execution with the peripheral bus clock off.
    acc(1'b1, `REG_CTRL, 32'h5);
    core_model_i.sleep(1'b1, 1'b0, 1'b0);
    rc(`REG_STATUS, 32'h108, "halt_status");
    chk("halt_bus", 32'h2, 32'({clk_gate.ahb, clk_gate.apb}));
    core_model_i.wake(8);
    repeat (4) @(posedge clk);
    chk("halt_apb_off", 32'h0, 32'(core_run));
    core_model_i.wake(5);
    wcore();
    mode(6'h04);
    acc(1'b1, `REG_CTRL, 32'he);
    for (int i = 0; i < 5; i++) begin
      core_model_i.sleep(1'b1, 1'b1, 1'b0);
      repeat (2) @(posedge clk);
      chk("stop", 32'h6, 32'({clk_gate.ahb, clk_gate.apb, fast_osc_suspend, lowclk_sel, fast_osc_run}));
      core_model_i.wake(7);
      repeat (4) @(posedge clk);
      chk("stop_core", 32'h0, 32'(core_run));
      core_model_i.wake(i);
      wcore();
      chk("fast_osc", 32'h1, 32'(fast_osc_run));
    end
    mode(6'h02);
    acc(1'b1, `REG_RST_EN, 32'h8);
    rc(`REG_RST_EN, 32'h8, "rst_en");
    core_model_i.sleep(1'b0, 1'b1, 1'b1);
    repeat (2) @(posedge clk);
    chk("deep", 32'h4, 32'({clk_gate, pins_low_power, std_ram_power, core_run}));
    core_model_i.wake(0);
    repeat (4) @(posedge clk);
    chk("deep_hold", 32'h4, 32'({reset_req, pins_low_power, std_ram_power, core_run}));
    core_model_i.wake(3);
    chk("reset_req", 32'h1, 32'(reset_req));
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (8) @(posedge clk);
    mode(6'h02);
    rc(`REG_CLK_EN, 32'hffff, "clk_en_reset");
    tally_and_finish();
  end
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
